/* src/dtc_timer.sv */
// dual 8-bit timer/counter with cascade, divider output and apb registers
//
// Behaviour
// - starting write also loads mode, clock, preset
// - cascade: low mode 011, high selects mode
// - cascade: low clock, high run and preset
// - high mode 1xx clocks high from overflow
// - selectable clocks depend on operating mode
// - timer counts prescaled clock, match clears, interrupts
// - compare register unbuffered, writes act at once
// - event mode counts input falling edges
// - divider match toggles flip-flop, clears, interrupts
// - divider pin is inverse flip-flop, reset high
// - stopped divider holds level, separate preset write
// - run is bit 3, preset bit 7
// - 00010001B selects fc/2^7 divider, stopped
`timescale 1ns/10ps
module dtc_timer
    import dtc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic low_event_input_pin,
    input wire logic high_event_input_pin,
    output logic low_divider_output_pin,
    output logic high_divider_output_pin,
    output logic counter_interrupt
);
    logic [7:0] ctrl_ff [2];
    logic [7:0] cmp_ff [2];
    logic [7:0] pw_ff [2];
    logic [7:0] cnt_ff [2];
    logic [1:0] tff_ff;
    logic [1:0] stat_ff;
    logic [1:0] mask_ff;
    logic [1:0] evt_prev_ff;
    logic [PRESCALE_BITS-1:0] pre_ff;
    logic [31:0] prdata_ff;
    logic pslverr_ff;

    wire setup = psel && !penable;
    wire access = psel && penable;
    wire wr = access && pwrite;
    wire rd = access && !pwrite;
    wire hit_ctrl0 = paddr == ADDR_LOW_CTRL;
    wire hit_ctrl1 = paddr == ADDR_HIGH_CTRL;
    wire hit_cmp0 = paddr == ADDR_LOW_CMP;
    wire hit_cmp1 = paddr == ADDR_HIGH_CMP;
    wire hit_pw0 = paddr == ADDR_LOW_PW;
    wire hit_pw1 = paddr == ADDR_HIGH_PW;
    wire hit_stat = paddr == ADDR_INT_STAT;
    wire hit_mask = paddr == ADDR_INT_MASK;
    wire hit_cnt = paddr == ADDR_COUNT;
    wire mapped = hit_ctrl0 || hit_ctrl1 || hit_cmp0 || hit_cmp1 || hit_pw0 || hit_pw1
        || hit_stat || hit_mask || hit_cnt;
    wire [1:0] wr_ctrl = {wr && hit_ctrl1, wr && hit_ctrl0};
    wire [1:0] wr_cmp = {wr && hit_cmp1, wr && hit_cmp0};
    wire [1:0] wr_pw = {wr && hit_pw1, wr && hit_pw0};
    wire [1:0] evt_pin = {high_event_input_pin, low_event_input_pin};

    // prescaler taps: each is a one-cycle enable at its divided rate
    wire tick_2_11 = &pre_ff[10:0];
    wire tick_2_7 = &pre_ff[6:0];
    wire tick_2_5 = &pre_ff[4:0];
    wire tick_2_3 = &pre_ff[2:0];
    wire tick_2_1 = pre_ff[0];

    // high mode 1xx joins both counters into one 16-bit unit
    wire cascade = ctrl_ff[1][CTRL_CASCADE_BIT];
    wire [15:0] cnt16 = {cnt_ff[1], cnt_ff[0]};
    wire [15:0] cnt16_inc = cnt16 + 16'h0001;
    wire match16 = cnt16_inc == {cmp_ff[1], cmp_ff[0]};

    logic [1:0] run;
    logic [1:0] tick;
    logic [1:0] match;
    logic [1:0] event_hit;
    logic [1:0] start;
    logic low_ovf;

    // in cascade the low half runs on the high run bit
    assign run[0] = cascade ? ctrl_ff[1][CTRL_RUN_BIT] : ctrl_ff[0][CTRL_RUN_BIT];
    assign run[1] = ctrl_ff[1][CTRL_RUN_BIT];
    assign low_ovf = tick[0] && (cnt_ff[0] == 8'hFF);

    genvar i;
    generate
        for (i = 0; i < 2; i++) begin : g_ch
            wire [2:0] ck = ctrl_ff[i][CTRL_CK_LSB +: 3];
            wire [2:0] mode = ctrl_ff[i][CTRL_MODE_LSB +: 3];
            wire fall = evt_prev_ff[i] && !evt_pin[i];
            wire [7:0] inc = cnt_ff[i] + 8'h01;
            logic src;
            // pin falling edges only when the pin source is chosen
            always_comb begin
                unique case (ck)
                    CK_DIV2_11: src = tick_2_11;
                    CK_DIV2_7: src = tick_2_7;
                    CK_DIV2_5: src = tick_2_5;
                    CK_DIV2_3: src = tick_2_3;
                    CK_DIV2: src = tick_2_1 && (mode == MODE_PWM);
                    CK_FC: src = (mode == MODE_PWM);
                    CK_PIN: src = fall && (mode == MODE_TIMER);
                    default: src = 1'b0;
                endcase
            end
            if (i == 0) begin : g_low
                assign tick[i] = run[i] && src;
                assign match[i] = cascade ? (tick[i] && match16) : (tick[i] && inc == cmp_ff[i]);
                assign event_hit[i] = !cascade && match[i];
            end else begin : g_high
                assign tick[i] = cascade ? low_ovf : (run[i] && src);
                assign match[i] = cascade ? match[0] : (tick[i] && inc == cmp_ff[i]);
                assign event_hit[i] = match[i];
            end
            // a write that raises run starts the counter
            assign start[i] = wr_ctrl[i] && pwdata[CTRL_RUN_BIT] && !ctrl_ff[i][CTRL_RUN_BIT];

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    ctrl_ff[i] <= CTRL_RESET;
                    cmp_ff[i] <= CMP_RESET;
                    pw_ff[i] <= PW_RESET;
                    cnt_ff[i] <= 8'h00;
                    tff_ff[i] <= 1'b0;
                    evt_prev_ff[i] <= 1'b1;
                end else begin
                    evt_prev_ff[i] <= evt_pin[i];
                    // settings are frozen while running; the run bit alone moves then
                    if (wr_ctrl[i] && (!ctrl_ff[i][CTRL_RUN_BIT] || !pwdata[CTRL_RUN_BIT])) begin
                        if (ctrl_ff[i][CTRL_RUN_BIT]) begin
                            ctrl_ff[i][CTRL_RUN_BIT] <= 1'b0;
                        end else begin
                            ctrl_ff[i] <= pwdata[7:0];
                        end
                    end
                    if (wr_cmp[i]) begin
                        cmp_ff[i] <= pwdata[7:0];
                    end
                    if (wr_pw[i]) begin
                        pw_ff[i] <= pwdata[7:0];
                    end
                    // preset lands only on a write made while stopped
                    if (wr_ctrl[i] && !ctrl_ff[i][CTRL_RUN_BIT] && !(i == 0 && cascade)) begin
                        tff_ff[i] <= pwdata[CTRL_PRESET_BIT];
                    end else if (event_hit[i] && mode == MODE_DIVIDER) begin
                        tff_ff[i] <= !tff_ff[i];
                    end
                    if (start[i] || (i == 0 && cascade && start[1])) begin
                        cnt_ff[i] <= 8'h00;
                    end else if (match[i]) begin
                        cnt_ff[i] <= 8'h00;
                    end else if (tick[i]) begin
                        cnt_ff[i] <= inc;
                    end
                end
            end
        end
    endgenerate

    // status bits are sticky; a new event beats the clear-on-read
    // only bits already captured for the reader are cleared, so an event at the setup edge survives
    wire clr_stat = rd && hit_stat;
    wire [1:0] clr_bits = clr_stat ? prdata_ff[1:0] : 2'h0;
    wire [1:0] nxt_stat_ff = (stat_ff & ~clr_bits) | event_hit;

    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (hit_ctrl0) rd_mux[7:0] = ctrl_ff[0];
        if (hit_ctrl1) rd_mux[7:0] = ctrl_ff[1];
        if (hit_cmp0) rd_mux[7:0] = cmp_ff[0];
        if (hit_cmp1) rd_mux[7:0] = cmp_ff[1];
        if (hit_pw0) rd_mux[7:0] = pw_ff[0];
        if (hit_pw1) rd_mux[7:0] = pw_ff[1];
        if (hit_stat) rd_mux[1:0] = stat_ff;
        if (hit_mask) rd_mux[1:0] = mask_ff;
        if (hit_cnt) rd_mux[15:0] = cnt16;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_ff <= '0;
            stat_ff <= 2'h0;
            mask_ff <= MASK_RESET;
            prdata_ff <= 32'h0000_0000;
            pslverr_ff <= 1'b0;
        end else begin
            pre_ff <= pre_ff + 1'b1;
            stat_ff <= nxt_stat_ff;
            if (wr && hit_mask) begin
                mask_ff <= pwdata[1:0];
            end
            // read data is captured in the setup cycle so prdata comes from a register
            if (setup) begin
                prdata_ff <= pwrite ? 32'h0000_0000 : rd_mux;
                pslverr_ff <= !mapped;
            end
        end
    end

    assign prdata = prdata_ff;
    assign pready = 1'b1;
    assign pslverr = pslverr_ff && access;
    assign low_divider_output_pin = !tff_ff[0];
    assign high_divider_output_pin = !tff_ff[1];
    assign counter_interrupt = |(stat_ff & mask_ff);
endmodule : dtc_timer

/* src/dtc_pkg.sv */
// constants shared by the dual 8-bit timer/counter
package dtc_pkg;
    localparam logic [7:0] ADDR_LOW_CTRL = 8'h00;
    localparam logic [7:0] ADDR_LOW_CMP = 8'h04;
    localparam logic [7:0] ADDR_LOW_PW = 8'h08;
    localparam logic [7:0] ADDR_HIGH_CTRL = 8'h0C;
    localparam logic [7:0] ADDR_HIGH_CMP = 8'h10;
    localparam logic [7:0] ADDR_HIGH_PW = 8'h14;
    localparam logic [7:0] ADDR_INT_STAT = 8'h18;
    localparam logic [7:0] ADDR_INT_MASK = 8'h1C;
    localparam logic [7:0] ADDR_COUNT = 8'h20;
    // control register fields
    localparam int CTRL_PRESET_BIT = 7;
    localparam int CTRL_CK_LSB = 4;
    localparam int CTRL_RUN_BIT = 3;
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_CASCADE_BIT = 2;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] CMP_RESET = 8'h00;
    localparam logic [7:0] PW_RESET = 8'h00;
    localparam logic [1:0] MASK_RESET = 2'h0;
    // mode field codes
    localparam logic [2:0] MODE_TIMER = 3'h0;
    localparam logic [2:0] MODE_DIVIDER = 3'h1;
    localparam logic [2:0] MODE_PWM = 3'h2;
    localparam logic [2:0] MODE_CASCADE_LOW = 3'h3;
    // clock select codes
    localparam logic [2:0] CK_DIV2_11 = 3'h0;
    localparam logic [2:0] CK_DIV2_7 = 3'h1;
    localparam logic [2:0] CK_DIV2_5 = 3'h2;
    localparam logic [2:0] CK_DIV2_3 = 3'h3;
    localparam logic [2:0] CK_DIV2 = 3'h4;
    localparam logic [2:0] CK_FC = 3'h5;
    localparam logic [2:0] CK_PIN = 3'h6;
    localparam int PRESCALE_BITS = 11;
endpackage : dtc_pkg

/* verification/dtc_properties.sv */
// port checker for the dual timer/counter
`timescale 1ns/10ps
module dtc_properties
    import dtc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic low_divider_output_pin,
    input wire logic high_divider_output_pin,
    input wire logic counter_interrupt
);
    logic acc;
    logic wr_hc;
    logic hrun_ff;
    assign acc = psel && penable;
    assign wr_hc = acc && pwrite && paddr == ADDR_HIGH_CTRL;
    // a start while running is ignored, so the last written run bit is the state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            hrun_ff <= 1'b0;
        else if (wr_hc)
            hrun_ff <= pwdata[CTRL_RUN_BIT];
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    ready_high_a: assert property (pready) else $error("pready low");
    err_access_only_a: assert property (pslverr |-> acc) else $error("pslverr outside access");
    unmapped_err_a: assert property (acc && paddr > ADDR_COUNT |-> pslverr && (pwrite || prdata == 32'h0000_0000))
        else $error("unmapped access not refused");
    mapped_ok_a: assert property (acc && paddr < ADDR_COUNT && paddr[1:0] == 2'h0 |-> !pslverr)
        else $error("mapped access refused");
    reset_pins_a: assert property (
        $rose(presetn) |-> low_divider_output_pin && high_divider_output_pin) else $error("pins low after reset");
    preset_load_a: assert property (
        wr_hc && !hrun_ff |=> high_divider_output_pin == !$past(pwdata[CTRL_PRESET_BIT]))
        else $error("stopped write did not load preset");
    stop_hold_a: assert property (
        wr_hc && hrun_ff && !pwdata[CTRL_RUN_BIT] |=> ##1 $stable(high_divider_output_pin))
        else $error("pin moved after stop");
    mask_off_a: assert property (acc && pwrite && paddr == ADDR_INT_MASK && pwdata[1:0] == 2'h0 |=> !counter_interrupt)
        else $error("interrupt high with mask clear");
endmodule : dtc_properties

/* verification/dtc_tb.sv */
// self-checking bench for the dual timer/counter
`timescale 1ns/10ps
module testbench;
    import dtc_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic low_event_input_pin = 1'b1;
    logic high_event_input_pin = 1'b1;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic pready, pslverr, err, p, low_divider_output_pin, high_divider_output_pin, counter_interrupt;
    int mismatches = 0, cmp_count = 0, seed = 39490, cyc = 0, t1, k, cmpv;
    dtc_timer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .low_event_input_pin(low_event_input_pin),
        .high_event_input_pin(high_event_input_pin), .low_divider_output_pin(low_divider_output_pin),
        .high_divider_output_pin(high_divider_output_pin), .counter_interrupt(counter_interrupt));
    initial begin
        forever #25 pclk = ~pclk;
    end
    always @(posedge pclk) cyc <= cyc + 1;
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : end_of_test
    // irq=1 waits for the interrupt, irq=0 for a change of the high divider pin
    task automatic wait_for(input bit irq, input int lim);
        int n;
        logic s;
        n = 0;
        s = high_divider_output_pin;
        do begin
            @(posedge pclk);
            n++;
            if (n > lim) begin
                chk("wait bound", 32'h0, 32'h1);
                end_of_test;
            end
        end while (irq ? counter_interrupt !== 1'b1 : high_divider_output_pin === s);
    endtask : wait_for
    // holds the request until pready is sampled high, takes read data and error at that edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
            if (n > 50) begin
                chk("pready bound", 32'h0, 32'h1);
                end_of_test;
            end
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic pulse;
        low_event_input_pin <= 1'b0;
        repeat (4) @(posedge pclk);
        low_event_input_pin <= 1'b1;
        repeat (4) @(posedge pclk);
    endtask : pulse
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        chk("pins after reset", 32'h0000_0003, 32'({low_divider_output_pin, high_divider_output_pin}));
        for (k = 0; k < 9; k++) begin
            apb(1'b0, 8'(k * 4), 32'h0);
            chk("reset value", 32'h0, rd);
        end
        apb(1'b0, 8'h24, 32'h0);
        chk("unmapped error", 32'h1, 32'(err));
        cmpv = 1 + ($unsigned($random(seed)) % 8);
        apb(1'b1, ADDR_INT_MASK, 32'h0000_0003);
        apb(1'b1, ADDR_LOW_CMP, 32'(cmpv));
        apb(1'b1, ADDR_LOW_CTRL, 32'h0000_0038);
        wait_for(1'b1, 200);
        t1 = cyc;
        apb(1'b0, ADDR_INT_STAT, 32'h0);
        chk("timer status", 32'h1, rd);
        wait_for(1'b1, 200);
        chk("timer period", 32'(cmpv * 8), 32'(cyc - t1));
        apb(1'b1, ADDR_LOW_CTRL, 32'h0000_0030);
        apb(1'b0, ADDR_INT_STAT, 32'h0);
        apb(1'b0, ADDR_COUNT, 32'h0);
        t1 = rd[7:0];
        repeat (40) @(posedge pclk);
        apb(1'b0, ADDR_COUNT, 32'h0);
        chk("stopped count", 32'(t1), rd & 32'h0000_00FF);
        apb(1'b1, ADDR_LOW_CMP, 32'h1);
        apb(1'b1, ADDR_LOW_CTRL, 32'h0000_0058);
        repeat (40) @(posedge pclk);
        apb(1'b1, ADDR_LOW_CTRL, 32'h0000_0050);
        apb(1'b0, ADDR_INT_STAT, 32'h0);
        chk("idle status", 32'h0, rd);
        cmpv = 2 + ($unsigned($random(seed)) % 4);
        apb(1'b1, ADDR_LOW_CMP, 32'(cmpv));
        apb(1'b1, ADDR_LOW_CTRL, 32'h0000_0068);
        for (k = 1; k < cmpv; k++) begin
            pulse();
            apb(1'b0, ADDR_COUNT, 32'h0);
            chk("event count", 32'(k), rd & 32'h0000_00FF);
        end
        pulse();
        wait_for(1'b1, 20);
        apb(1'b1, ADDR_INT_MASK, 32'h0);
        @(posedge pclk);
        chk("masked interrupt", 32'h0, 32'(counter_interrupt));
        apb(1'b0, ADDR_INT_STAT, 32'h0);
        chk("event status", 32'h1, rd);
        apb(1'b1, ADDR_LOW_CTRL, 32'h0000_0060);
        apb(1'b1, ADDR_HIGH_CMP, 32'h2);
        apb(1'b1, ADDR_HIGH_CTRL, 32'h0000_0011);
        @(posedge pclk);
        chk("divider pin idle", 32'h1, 32'(high_divider_output_pin));
        apb(1'b1, ADDR_HIGH_CTRL, 32'h0000_0019);
        wait_for(1'b0, 1000);
        t1 = cyc;
        wait_for(1'b0, 1000);
        chk("half period", 32'(2 * 128), 32'(cyc - t1));
        apb(1'b1, ADDR_HIGH_CTRL, 32'h0000_0011);
        @(posedge pclk);
        p = high_divider_output_pin;
        repeat (300) @(posedge pclk);
        chk("held pin", 32'(p), 32'(high_divider_output_pin));
        apb(1'b0, ADDR_INT_STAT, 32'h0);
        chk("divider status", 32'h2, rd);
        apb(1'b1, ADDR_HIGH_CTRL, 32'h0000_0091);
        @(posedge pclk);
        chk("preset pin", 32'h0, 32'(high_divider_output_pin));
        // cascade: compare 0x0100 on the low fc/2^3 clock, high clock select ignored
        apb(1'b1, ADDR_LOW_CMP, 32'h0000_0000);
        apb(1'b1, ADDR_LOW_CTRL, 32'h0000_0033);
        apb(1'b1, ADDR_HIGH_CMP, 32'h0000_0001);
        apb(1'b1, ADDR_INT_MASK, 32'h0000_0003);
        apb(1'b1, ADDR_HIGH_CTRL, 32'h0000_000C);
        wait_for(1'b1, 5000);
        t1 = cyc;
        apb(1'b0, ADDR_INT_STAT, 32'h0);
        chk("cascade status", 32'h2, rd);
        wait_for(1'b1, 5000);
        chk("cascade period", 32'(256 * 8), 32'(cyc - t1));
        end_of_test;
    end
endmodule : testbench
bind dtc_timer dtc_properties chk_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .low_divider_output_pin(low_divider_output_pin), .high_divider_output_pin(high_divider_output_pin),
    .counter_interrupt(counter_interrupt));
